// file: rtl/csr_regs.svh
`ifndef CSR_REGS_SVH
`define CSR_REGS_SVH

// ==========================================================
// system register byte addresses (four times the number)
`define CSR_STATUS_OFF    10'h000
`define CSR_EXCEPTION_VECTOR_BASE_OFF      10'h004
`define CSR_APP_CALL_TABLE_BASE_OFF      10'h008
`define CSR_CTRL_OFF      10'h00C
`define CSR_CAUSE_OFF     10'h010
`define CSR_DBG_RSR_OFF   10'h030
`define CSR_DBG_RAR_OFF   10'h050
`define CSR_CFG_A_OFF     10'h100
`define CSR_CFG_B_OFF     10'h104
`define CSR_COUNT_OFF     10'h108
`define CSR_COMPARE_OFF   10'h10C

// ==========================================================
// status word bit positions
`define CSR_C_BIT      0
`define CSR_Z_BIT      1
`define CSR_N_BIT      2
`define CSR_V_BIT      3
`define CSR_Q_BIT      4
`define CSR_L_BIT      5
`define CSR_T_BIT      14
`define CSR_GM_BIT     16
`define CSR_I0M_BIT    17
`define CSR_EM_BIT     21
`define CSR_MODE_LSB   22
`define CSR_DM_BIT     26
`define CSR_D_BIT      27
`define CSR_SS_BIT     31

// ==========================================================
// reset values, write masks and control bit positions
`define CSR_STATUS_RST 32'h00610000
`define CSR_WMASK_LO   32'h0000403F
`define CSR_WMASK_HI   32'h043F0000
`define CSR_RET_MASK   32'h07FF403F
`define CSR_CTRL_RST   2'h0
`define CSR_NOCLR_BIT  1
`define CSR_LOCEN_BIT  0

`endif

// file: rtl/csr_pkg.sv
package csr_pkg;
  typedef enum logic [2:0] {
    CSR_MODE_APP  = 3'h0,
    CSR_MODE_SUP  = 3'h1,
    CSR_MODE_INT0 = 3'h2,
    CSR_MODE_INT1 = 3'h3,
    CSR_MODE_INT2 = 3'h4,
    CSR_MODE_IRQ_LEVEL_THREE = 3'h5,
    CSR_MODE_EXC  = 3'h6,
    CSR_MODE_NMI  = 3'h7
  } csr_mode_type;

  typedef struct packed {
    logic [31:0] status;
    logic [31:0] exception_vector_base;
    logic [31:0] app_call_table_base;
    logic [1:0]  ctrl;
    logic [31:0] cause;
    logic [31:0] dbg_rsr;
    logic [31:0] dbg_rar;
    logic [31:0] count;
    logic [31:0] compare;
    logic [31:0] rdata;
    logic        match;
  } csr_state_type;
endpackage

// file: rtl/csr_status_sysreg.sv
`include "csr_regs.svh"

// Function
// R1: secure flag follows secure execution; forced zero before revision 3
// R2: debug-entry mask blocks debug entry; resets zero; software read/write
// R3: debug bit set only in debug state; set by debug entry, cleared by return
// R4: mode field encodes application, supervisor, four levels, exception, nmi
// R5: reset starts the core in supervisor mode
// R6: mode changes only on entries and call/return, not by generic moves
// R7: exception mask blocks exceptions; set on exception/debug entry and reset
// R8: level three taken only when its mask and global mask clear
// R9: level two mask gates level two; set on level three or two entry
// R10: level one mask gates level one; set on entry to levels three to one
// R11: level zero mask gates level zero; set on any interrupt entry
// R12: global mask disables all levels; set on exception, debug and reset
// R13: scratch bit never altered as a side effect; resets zero
// R14: lock flag for conditional store; cleared by exception return and reset
// R15: saturation flag sticky until explicitly cleared by flag clear; here a privileged status move or a return can also clear it
// R16: overflow, negative, zero, carry updated by arithmetic and logic
// R17: upper status half accessible only in privileged modes
// R18: system registers reached only by privileged move instructions
// R19: software sequences instructions after a system register write
// R20: each system register address is four times its number
// R21: debug return status and address registers implemented
// R22: reserved numbers, configuration, counter and compare placement
// R23: unused numbers read zero and ignore writes
module csr_status_sysreg #(
  parameter int          ARCH_REV = 3,
  parameter logic        SS_RESET = 1'b0,
  parameter logic [31:0] CONFIG_A = 32'h00000000,
  parameter logic [31:0] CONFIG_B = 32'h00000000
) (
  // clock and reset
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst_n,
  // system register moves
  input  wire logic                  i_mtsr,
  input  wire logic                  i_mfsr,
  input  wire logic [9:0]            i_sr_addr,
  input  wire logic [31:0]           i_wdata,
  output logic      [31:0]           o_rdata,
  output logic                       o_access_fault,
  // flag instructions and datapath
  input  wire logic                  i_flag_set,
  input  wire logic                  i_flag_clr,
  input  wire logic [4:0]            i_flag_idx,
  input  wire logic                  i_alu_we,
  input  wire logic [3:0]            i_alu_flags,
  input  wire logic                  i_sat_ovf,
  // mode events
  input  wire logic                  i_dbg_req,
  input  wire logic                  i_bkpt,
  input  wire logic                  i_retd,
  input  wire logic                  i_exc_take,
  input  wire logic [31:0]           i_exc_cause,
  input  wire logic                  i_nmi_take,
  input  wire logic                  i_irq_take,
  input  wire logic [1:0]            i_irq_level,
  input  wire logic                  i_scall,
  input  wire logic                  i_rets,
  input  wire logic                  i_rete,
  input  wire logic [31:0]           i_ret_status,
  input  wire logic [31:0]           i_pc,
  input  wire logic                  i_secure,
  // status outputs
  output logic      [31:0]           o_status,
  output csr_pkg::csr_mode_type      o_mode,
  output logic      [3:0]            o_irq_enable,
  output logic                       o_exc_enable,
  output logic                       o_debug_state,
  output logic                       o_compare_match
);
  import csr_pkg::*;

  initial begin
    if (ARCH_REV < 1) begin
      $error("csr_status_sysreg: ARCH_REV must be at least 1");
    end
  end

  localparam logic HAS_SS = (ARCH_REV >= 3);

  csr_state_type st;
  csr_state_type next_st;

  // ==========================================================
  // decode
  logic       priv;
  logic       dbg_take;
  logic       irq_ok;
  logic       hit;
  logic [31:0] rd_val;
  logic [31:0] wmask;

  assign priv     = (st.status[`CSR_MODE_LSB +: 3] != CSR_MODE_APP); // R17
  // the debug request is simply dropped while masked or already in debug
  assign dbg_take = (i_dbg_req | i_bkpt) & ~st.status[`CSR_DM_BIT]
                    & ~st.status[`CSR_D_BIT]; // R2
  assign irq_ok   = i_irq_take & o_irq_enable[i_irq_level]; // R8 R9 R10 R11
  assign wmask    = priv ? (`CSR_WMASK_LO | `CSR_WMASK_HI) : `CSR_WMASK_LO;

  // moves are privileged; an application-mode attempt is flagged and dropped
  assign o_access_fault = (i_mtsr | i_mfsr) & ~priv; // R18

  always_comb begin
    hit    = 1'b1;
    rd_val = 32'h00000000;
    unique case (i_sr_addr) // R20 R22
      `CSR_STATUS_OFF:  rd_val = st.status;
      `CSR_EXCEPTION_VECTOR_BASE_OFF:    rd_val = st.exception_vector_base;
      `CSR_APP_CALL_TABLE_BASE_OFF:    rd_val = st.app_call_table_base;
      `CSR_CTRL_OFF:    rd_val = {14'h0000, st.ctrl, 16'h0000};
      `CSR_CAUSE_OFF:   rd_val = st.cause;
      `CSR_DBG_RSR_OFF: rd_val = st.dbg_rsr; // R21
      `CSR_DBG_RAR_OFF: rd_val = st.dbg_rar; // R21
      `CSR_CFG_A_OFF:   rd_val = CONFIG_A;
      `CSR_CFG_B_OFF:   rd_val = CONFIG_B;
      `CSR_COUNT_OFF:   rd_val = st.count;
      `CSR_COMPARE_OFF: rd_val = st.compare;
      default:          hit    = 1'b0; // R23
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    next_st = st;

    // cycle counter, cleared on match unless the control bit forbids it
    next_st.match = (st.count == st.compare);
    if (next_st.match && !st.ctrl[`CSR_NOCLR_BIT]) begin
      next_st.count = 32'h00000000;
    end else begin
      next_st.count = st.count + 32'h00000001;
    end

    // datapath flags
    if (i_alu_we) begin
      next_st.status[`CSR_V_BIT:`CSR_C_BIT] = i_alu_flags; // R16
    end

    // flag set/clear instructions; mode, debug and secure bits never move
    if (i_flag_clr && wmask[i_flag_idx]) begin
      next_st.status[i_flag_idx] = 1'b0; // R15
    end
    if (i_flag_set && wmask[i_flag_idx]) begin
      next_st.status[i_flag_idx] = 1'b1;
    end

    // privileged moves; only the documented bits take the write
    if (i_mtsr && priv) begin // R18 R19
      unique case (i_sr_addr)
        `CSR_STATUS_OFF:  next_st.status = (st.status & ~wmask)
                                           | (i_wdata & wmask); // R6 R13
        `CSR_EXCEPTION_VECTOR_BASE_OFF:    next_st.exception_vector_base = i_wdata;
        `CSR_APP_CALL_TABLE_BASE_OFF:    next_st.app_call_table_base = i_wdata;
        `CSR_CTRL_OFF:    next_st.ctrl = i_wdata[17:16];
        `CSR_DBG_RSR_OFF: next_st.dbg_rsr = i_wdata;
        `CSR_DBG_RAR_OFF: next_st.dbg_rar = i_wdata;
        `CSR_COUNT_OFF:   next_st.count = i_wdata;
        `CSR_COMPARE_OFF: next_st.compare = i_wdata;
        default:          next_st.count = next_st.count; // R23
      endcase
    end

    // sticky saturation: a set wins over a flag clear or status move in the same cycle, but a return overrides it
    if (i_sat_ovf) begin
      next_st.status[`CSR_Q_BIT] = 1'b1; // R15
    end

    // call sets supervisor mode; returns restore the saved word, keeping secure; rets/rete keep debug, retd clears it
    if (i_scall) begin
      next_st.status[`CSR_MODE_LSB +: 3] = CSR_MODE_SUP; // R6
    end
    if (i_rets || i_rete) begin
      next_st.status = (st.status & ~`CSR_RET_MASK)
                       | (i_ret_status & `CSR_RET_MASK); // R6
      if (i_rete) begin
        next_st.status[`CSR_L_BIT] = 1'b0; // R14
      end
    end
    if (i_retd && st.status[`CSR_D_BIT]) begin
      next_st.status = (st.status & ~`CSR_RET_MASK)
                       | (st.dbg_rsr & `CSR_RET_MASK);
      next_st.status[`CSR_D_BIT] = 1'b0; // R3
    end

    // entries, in rising priority: interrupt, nmi, exception, debug
    if (irq_ok) begin
      next_st.status[`CSR_MODE_LSB +: 3] = 3'(CSR_MODE_INT0)
                                           + {1'b0, i_irq_level}; // R4
      for (int k = 0; k < 4; k++) begin
        if (k <= int'(i_irq_level)) begin
          next_st.status[`CSR_I0M_BIT + k] = 1'b1; // R8 R9 R10 R11
        end
      end
    end
    if (i_nmi_take) begin
      next_st.status[`CSR_MODE_LSB +: 3] = CSR_MODE_NMI;
      next_st.status[`CSR_EM_BIT] = 1'b1;
      next_st.status[`CSR_GM_BIT] = 1'b1;
    end
    if (i_exc_take && o_exc_enable) begin
      next_st.status[`CSR_MODE_LSB +: 3] = CSR_MODE_EXC; // R6
      next_st.status[`CSR_EM_BIT] = 1'b1; // R7
      next_st.status[`CSR_GM_BIT] = 1'b1; // R12
      next_st.cause = i_exc_cause;
    end
    if (dbg_take) begin
      next_st.dbg_rsr = st.status;
      next_st.dbg_rar = i_pc;
      next_st.status[`CSR_D_BIT]  = 1'b1; // R3
      next_st.status[`CSR_EM_BIT] = 1'b1; // R7
      next_st.status[`CSR_GM_BIT] = 1'b1; // R12
    end

    // secure flag tracks the execution state; older revisions tie it low
    next_st.status[`CSR_SS_BIT] = HAS_SS & i_secure; // R1

    // read data is registered so the move answers one cycle later
    next_st.rdata = (i_mfsr && priv && hit) ? rd_val : 32'h00000000;
  end

  // ==========================================================
  // state register
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st                     <= '0;
      st.status              <= `CSR_STATUS_RST; // R5 R7 R12 R13 R14
      st.status[`CSR_SS_BIT] <= HAS_SS & SS_RESET; // R1
      st.ctrl                <= `CSR_CTRL_RST;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  assign o_status        = st.status;
  assign o_mode          = csr_mode_type'(st.status[`CSR_MODE_LSB +: 3]);
  assign o_exc_enable    = ~st.status[`CSR_EM_BIT]; // R7
  assign o_debug_state   = st.status[`CSR_D_BIT]; // R3
  assign o_rdata         = st.rdata;
  assign o_compare_match = st.match;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lvl
      assign o_irq_enable[g] = ~st.status[`CSR_I0M_BIT + g]
                               & ~st.status[`CSR_GM_BIT]; // R12
    end
  endgenerate

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_dbg_req_masked;
    (i_dbg_req | i_bkpt) && st.status[`CSR_DM_BIT] && !o_debug_state;
  endsequence

  property p_dm_blocks;
    s_dbg_req_masked and !i_retd |=> !o_debug_state;
  endproperty
  a_dm_blocks: assert property (p_dm_blocks) // R2
    else $error("debug entered while masked");

  sequence s_dbg_entry;
    dbg_take;
  endsequence

  property p_dbg_entry;
    s_dbg_entry |=> o_debug_state && !o_exc_enable
                    && o_irq_enable == 4'h0 && st.dbg_rar == $past(i_pc);
  endproperty
  a_dbg_entry: assert property (p_dbg_entry) // R3
    else $error("debug entry did not set state and masks");

  property p_irq_mode;
    irq_ok && !i_nmi_take && !i_exc_take && !dbg_take |=>
      o_mode == csr_mode_type'(3'(CSR_MODE_INT0) + {1'b0, $past(i_irq_level)})
      && o_irq_enable[$past(i_irq_level)] == 1'b0;
  endproperty
  a_irq_mode: assert property (p_irq_mode) // R4
    else $error("interrupt entry mode wrong");

  property p_gm_override;
    st.status[`CSR_GM_BIT] |-> o_irq_enable == 4'h0;
  endproperty
  a_gm_override: assert property (p_gm_override) // R12
    else $error("interrupt enabled under global mask");

  property p_lvl3_mask;
    irq_ok && i_irq_level == 2'h3 && !i_nmi_take && !i_exc_take
      && !dbg_take |=> o_irq_enable == 4'h0;
  endproperty
  a_lvl3_mask: assert property (p_lvl3_mask) // R8
    else $error("level three entry left a level enabled");

  property p_exc_entry;
    i_exc_take && o_exc_enable && !dbg_take |=>
      o_mode == CSR_MODE_EXC && !o_exc_enable && st.cause == $past(i_exc_cause);
  endproperty
  a_exc_entry: assert property (p_exc_entry) // R7
    else $error("exception entry incomplete");

  property p_rete_lock;
    i_rete && !i_flag_set && !(i_mtsr && priv) |=> !st.status[`CSR_L_BIT];
  endproperty
  a_rete_lock: assert property (p_rete_lock) // R14
    else $error("lock survived exception return");

  property p_sat_sticky;
    st.status[`CSR_Q_BIT] && !i_flag_clr && !i_mtsr && !i_rets && !i_rete
      && !i_retd |=> st.status[`CSR_Q_BIT];
  endproperty
  a_sat_sticky: assert property (p_sat_sticky) // R15
    else $error("saturation flag dropped without clear");

  property p_unmapped_zero;
    i_mfsr && !hit |=> o_rdata == 32'h00000000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) // R23
    else $error("unmapped register read not zero");

  property p_user_no_upper;
    i_mfsr && !priv |=> o_rdata == 32'h00000000;
  endproperty
  a_user_no_upper: assert property (p_user_no_upper) // R17
    else $error("application mode read returned data");

  property p_ss_old_rev;
    !HAS_SS |-> !o_status[`CSR_SS_BIT];
  endproperty
  a_ss_old_rev: assert property (p_ss_old_rev) // R1
    else $error("secure flag set on old revision");
endmodule

// file: testbench/testbench.sv
`include "csr_regs.svh"

module testbench;
  import csr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic          i_ref_clk, i_rst_n, i_mtsr, i_mfsr;
  logic [9:0]    i_sr_addr;
  logic [31:0]   i_wdata, i_exc_cause, i_ret_status, i_pc, o_rdata, o_status;
  logic          i_flag_set, i_flag_clr, i_alu_we, i_sat_ovf, i_dbg_req;
  logic [4:0]    i_flag_idx;
  logic [3:0]    i_alu_flags, o_irq_enable;
  logic          i_bkpt, i_retd, i_exc_take, i_nmi_take, i_irq_take;
  logic [1:0]    i_irq_level;
  logic          i_scall, i_rets, i_rete, i_secure, o_access_fault;
  logic          o_exc_enable, o_debug_state, o_compare_match;
  csr_mode_type  o_mode;
  logic [31:0]   d;
  int            fails = 0;
  int            compares = 0;

  csr_status_sysreg csr_status_sysreg_i (.*);

  // ==========================================================
  // clock, helpers
  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end

  task automatic go;
    @(posedge i_ref_clk);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] v);
    go;
    i_mtsr    <= 1'b1;
    i_sr_addr <= a;
    i_wdata   <= v;
    go;
    i_mtsr <= 1'b0;
  endtask

  // read data is registered: sampled just after the edge taking the strobe
  task automatic rd(input logic [9:0] a, output logic [31:0] v);
    go;
    i_mfsr    <= 1'b1;
    i_sr_addr <= a;
    go;
    i_mfsr <= 1'b0;
    #1 v = o_rdata;
  endtask

  task automatic rdchk(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(v, e);
  endtask

  task automatic summarize;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) go;
    fails++;
    summarize;
  end

  // ==========================================================
  // tests
  logic [9:0]  addrs [5] = '{`CSR_EXCEPTION_VECTOR_BASE_OFF, `CSR_APP_CALL_TABLE_BASE_OFF, `CSR_DBG_RSR_OFF,
                             `CSR_DBG_RAR_OFF, `CSR_COMPARE_OFF};
  logic [31:0] vals [5] = '{32'h80000000, 32'h00001000, 32'h12345678,
                            32'h9ABCDEF0, 32'h00FFFFFF};
  logic [9:0]  holes [4] = '{10'h014, 10'h084, 10'h0FC, 10'h3FC};

  initial begin
    {i_mtsr, i_mfsr, i_flag_set, i_flag_clr, i_alu_we, i_sat_ovf} = '0;
    {i_dbg_req, i_bkpt, i_retd, i_exc_take, i_nmi_take, i_irq_take} = '0;
    {i_scall, i_rets, i_rete, i_secure} = '0;
    i_sr_addr = '0; i_wdata = '0; i_flag_idx = '0; i_alu_flags = '0;
    i_exc_cause = '0; i_irq_level = '0; i_ret_status = '0; i_pc = '0;
    i_rst_n = 1'b0;
    repeat (5) go;
    #1 chk(o_status, `CSR_STATUS_RST);
    chk({29'h0, o_mode}, CSR_MODE_SUP);
    chk({o_irq_enable, o_exc_enable, o_debug_state}, 6'h0);
    i_rst_n <= 1'b1;

    for (int k = 0; k < 5; k++) wr(addrs[k], vals[k]);
    for (int k = 0; k < 5; k++) rdchk(addrs[k], vals[k]);
    for (int k = 0; k < 4; k++) begin
      wr(holes[k], 32'hFFFFFFFF);
      rdchk(holes[k], 32'h0);
    end
    wr(`CSR_CAUSE_OFF, 32'h00000055);
    rdchk(`CSR_CAUSE_OFF, 32'h0);
    wr(`CSR_CTRL_OFF, 32'hFFFFFFFF);
    rdchk(`CSR_CTRL_OFF, 32'h00030000);
    $display("test registers done");

    // mode, debug and secure bits ignore generic writes
    wr(`CSR_STATUS_OFF, 32'hFFFFFFFF);
    rdchk(`CSR_STATUS_OFF, 32'h047F403F);
    wr(`CSR_STATUS_OFF, 32'h0);
    #1 chk(o_status, 32'h00400000);
    chk({o_irq_enable, o_exc_enable}, 5'h1F);
    go; i_irq_take <= 1'b1; i_irq_level <= 2'h2;
    go; i_irq_take <= 1'b0;
    #1 chk(o_status, 32'h010E0000);
    chk({28'h0, o_irq_enable}, 32'h8);
    go; i_irq_take <= 1'b1; i_irq_level <= 2'h1;
    go; i_irq_level <= 2'h3;
    #1 chk(o_status, 32'h010E0000);
    go; i_irq_take <= 1'b0;
    #1 chk(o_status, 32'h015E0000);
    chk({28'h0, o_irq_enable}, 32'h0);
    go; i_rete <= 1'b1; i_ret_status <= 32'h00400020;
    go; i_rete <= 1'b0;
    #1 chk(o_status, 32'h00400000);
    $display("test interrupts done");

    go; i_alu_we <= 1'b1; i_alu_flags <= 4'hF;
    go; i_alu_we <= 1'b0; i_flag_set <= 1'b1; i_flag_idx <= 5'd14;
    go; i_flag_set <= 1'b0; i_sat_ovf <= 1'b1;
    go; i_sat_ovf <= 1'b0; i_alu_we <= 1'b1; i_alu_flags <= 4'h0;
    #1 chk(o_status, 32'h0040401F);
    go; i_alu_we <= 1'b0; i_flag_clr <= 1'b1; i_flag_idx <= 5'd4;
    #1 chk(o_status, 32'h00404010);
    go; i_flag_idx <= 5'd14;
    #1 chk(o_status, 32'h00404000);
    go; i_flag_clr <= 1'b0;
    #1 chk(o_status, 32'h00400000);
    $display("test flags done");

    wr(`CSR_STATUS_OFF, 32'h00010000);
    go; i_irq_take <= 1'b1; i_irq_level <= 2'h0;
    go; i_irq_take <= 1'b0;
    #1 chk(o_status, 32'h00410000);
    chk({28'h0, o_irq_enable}, 32'h0);
    go; i_exc_take <= 1'b1; i_exc_cause <= 32'h00000123;
    go; i_exc_cause <= 32'h00000007;
    go; i_exc_take <= 1'b0;
    #1 chk(o_status, 32'h01A10000);
    rdchk(`CSR_CAUSE_OFF, 32'h00000123);
    $display("test exception done");

    wr(`CSR_STATUS_OFF, 32'h04000000);
    go; i_dbg_req <= 1'b1;
    go; i_dbg_req <= 1'b0;
    #1 chk(o_debug_state, 1'b0);
    chk(o_status, 32'h05800000);
    wr(`CSR_STATUS_OFF, 32'h0);
    go; i_bkpt <= 1'b1; i_pc <= 32'h00000ABC;
    go; i_bkpt <= 1'b0;
    #1 chk({o_debug_state, o_status[27], o_status[21], o_status[16]},
           4'hF);
    rdchk(`CSR_DBG_RAR_OFF, 32'h00000ABC);
    rdchk(`CSR_DBG_RSR_OFF, 32'h01800000);
    go; i_retd <= 1'b1; i_ret_status <= 32'h00400000;
    go; i_retd <= 1'b0;
    #1 chk(o_status, 32'h01800000);
    $display("test debug done");

    go; i_rets <= 1'b1; i_ret_status <= 32'h0;
    go; i_rets <= 1'b0;
    #1 chk({29'h0, o_mode}, CSR_MODE_APP);
    go; i_mtsr <= 1'b1; i_sr_addr <= `CSR_EXCEPTION_VECTOR_BASE_OFF; i_wdata <= 32'hDEAD;
    #1 chk(o_access_fault, 1'b1);
    go; i_mtsr <= 1'b0;
    rd(`CSR_STATUS_OFF, d);
    chk(d, 32'h0);
    go; i_scall <= 1'b1;
    go; i_scall <= 1'b0;
    #1 chk({29'h0, o_mode}, CSR_MODE_SUP);
    rdchk(`CSR_EXCEPTION_VECTOR_BASE_OFF, 32'h80000000);
    go; i_secure <= 1'b1;
    go;
    go;
    #1 chk(o_status[31], 1'b1);
    $display("test privilege done");
    wr(`CSR_COUNT_OFF, 32'h00000005);
    wr(`CSR_COMPARE_OFF, 32'h00000008);
    go;
    go;
    #1 chk(o_compare_match, 1'b1);
    go;
    #1 chk(o_compare_match, 1'b0);
    $display("test counter done");
    summarize;
  end
endmodule
